// >>> rtl/hot_swap_status_flags.sv
// Status byte logic of the hot swap controller with its serial read port.
// Assumes alert enables, clear request and software switch-off come from
// the control registers on this clock; on pin and switch state are async.
// Contract
// - Bit0 high when last three conversions over
// - Bit1 latches on conversion trip, clear clears
// - Latch-off with enable: bit2 equals failure flag
// - Retry variants: bit2 shows live overcurrent only
// - Bit3 latches on switch failure until cleared
// - Bit4 reads one while on input deasserted
// - Software switch-off also forces bit4 high
// - Bit5 latches on switch-off until cleared
// - Clear bit returns to zero by itself
// - Persisting enabled conversion or failure source sets flag despite clear
// - Status byte read after address with read bit, repeated while the master acknowledges
`timescale 1ns/100ps
`include "hot_swap_status_consts.svh"
module hot_swap_status_flags
    import hot_swap_status_pkg::*;
#(
    parameter bit AUTO_RETRY = 1'b1,
    parameter logic [6:0] DEV_ADDR = `SER_ADDR_DEFAULT
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic conv_done_i,
    input wire logic conv_over_i,
    input wire alert_en_s alert_en_i,
    input wire logic clear_req_i,
    input wire logic software_switch_off_i,
    input wire logic on_pin_i,
    input wire logic switch_overcurrent_raw_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    output logic [7:0] hot_swap_status_flags_o,
    output logic clear_busy_o
);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    ////////////////////////////////////////////////////////////////////////////
    // Async inputs: three stages, level taken when stages two and three agree
    // Reset to the idle pin levels; a switch-off level here would fake an off
    // edge on leaving reset and latch the off alert with nothing switched off
    localparam logic [1:0] PIN_IDLE = `PIN_SYNC_RESET;
    logic [1:0] pin_raw, pin_f_q;
    logic [2:0] pin_s_q [2];
    assign pin_raw = {switch_overcurrent_raw_i, on_pin_i};
    for (genvar g = 0; g < 2; g++) begin : g_sync
        always_ff @(posedge clk_i) begin
            if (sys_rst_i) begin
                pin_s_q[g] <= {3{PIN_IDLE[g]}};
                pin_f_q[g] <= PIN_IDLE[g];
            end else begin
                pin_s_q[g] <= {pin_s_q[g][1:0], pin_raw[g]};
                if (pin_s_q[g][1] == pin_s_q[g][2]) pin_f_q[g] <= pin_s_q[g][2];
            end
        end
    end

    logic on_f, switch_overcurrent_state;
    assign on_f = pin_f_q[0];
    assign switch_overcurrent_state = pin_f_q[1];

    ////////////////////////////////////////////////////////////////////////////
    // Run of consecutive over-threshold conversions, saturating
    logic [2:0] run_q;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            run_q <= 3'h0;
        end else if (conv_done_i) begin
            if (!conv_over_i) run_q <= 3'h0;
            else if (run_q != `CONV_RUN_MAX) run_q <= run_q + 3'h1;
        end
    end

    logic conv_overcurrent_now;
    assign conv_overcurrent_now = (run_q >= `CONV_RUN_LEN);

    ////////////////////////////////////////////////////////////////////////////
    // Conversion and failure sources are levels, so one that persists re-arms its flag; off source is an edge
    logic conv_src, fail_src, off_src, off_state_d, off_state_q;
    assign conv_src = (alert_en_i.conv_single && run_q != 3'h0)
        || (alert_en_i.conv_four && run_q >= `CONV_TRIP_LEN);
    assign fail_src = alert_en_i.failure_alert_enable && switch_overcurrent_state;
    assign off_state_d = ~on_f | software_switch_off_i;
    assign off_src = alert_en_i.off_alert && off_state_d && !off_state_q;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) off_state_q <= 1'b0;
        else off_state_q <= off_state_d;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clear bit: set by the register write, drops after one clearing cycle
    logic clear_q;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) clear_q <= 1'b0;
        else if (clear_req_i) clear_q <= 1'b1;
        else if (clear_q) clear_q <= 1'b0;
    end
    assign clear_busy_o = clear_q;

    ////////////////////////////////////////////////////////////////////////////
    // Sticky flags; set beats clear so an event in the clear cycle survives
    logic conv_alert_q, fail_q, off_alert_q, fail_d;
    assign fail_d = fail_src ? 1'b1 : (clear_q ? 1'b0 : fail_q);

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) conv_alert_q <= 1'b0;
        else conv_alert_q <= conv_src ? 1'b1 : (clear_q ? 1'b0 : conv_alert_q);
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) fail_q <= 1'b0;
        else fail_q <= fail_d;
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) off_alert_q <= 1'b0;
        else off_alert_q <= off_src ? 1'b1 : (clear_q ? 1'b0 : off_alert_q);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Overcurrent state bit, variant dependent
    logic sw_oc_q, conv_now_q;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) sw_oc_q <= 1'b0;
        else if (AUTO_RETRY) sw_oc_q <= switch_overcurrent_state;
        else if (alert_en_i.failure_alert_enable) sw_oc_q <= fail_d;
        else sw_oc_q <= switch_overcurrent_state;
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) conv_now_q <= 1'b0;
        else conv_now_q <= conv_overcurrent_now;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Byte assembly; top two bits read zero
    always_comb begin
        hot_swap_status_flags_o = `STATUS_RESET;
        hot_swap_status_flags_o[`ST_CONV_NOW] = conv_now_q;
        hot_swap_status_flags_o[`ST_CONV_ALERT] = conv_alert_q;
        hot_swap_status_flags_o[`ST_SW_OC] = sw_oc_q;
        hot_swap_status_flags_o[`ST_FAIL_ALERT] = fail_q;
        hot_swap_status_flags_o[`ST_OFF_STATE] = off_state_q;
        hot_swap_status_flags_o[`ST_OFF_ALERT] = off_alert_q;
    end

    status_serial_slave #(
        .DEV_ADDR(DEV_ADDR)
    ) u_ser (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .tx_byte_i(hot_swap_status_flags_o),
        .sda_o(sda_o),
        .sda_oe_o(sda_oe_o)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    AST_CONV_NOW_DROP: assert property (
        conv_done_i && !conv_over_i |=> ##1 !hot_swap_status_flags_o[0])
        else $error("Conversion overcurrent bit stayed high after a low conversion");

    AST_CONV_NOW_RISE: assert property (
        $rose(hot_swap_status_flags_o[0]) |-> $past(conv_done_i, 2) && $past(conv_over_i, 2))
        else $error("Conversion overcurrent bit rose without an over conversion");

    AST_CONV_ALERT_HOLD: assert property (
        hot_swap_status_flags_o[1] && !clear_q |=> hot_swap_status_flags_o[1])
        else $error("Conversion alert dropped without a clear");

    AST_SW_OC_MIRROR: assert property (
        !AUTO_RETRY && alert_en_i.failure_alert_enable && $stable(alert_en_i)
        |-> hot_swap_status_flags_o[2] == hot_swap_status_flags_o[3])
        else $error("Latch-off overcurrent bit differs from failure flag");

    AST_SW_OC_LIVE: assert property (
        AUTO_RETRY && !pin_f_q[1] |=> !hot_swap_status_flags_o[2])
        else $error("Retry overcurrent bit high with no live overcurrent");

    AST_FAIL_SET: assert property (
        fail_src |=> hot_swap_status_flags_o[3])
        else $error("Failure flag not set by enabled failure");

    AST_OFF_STATE: assert property (
        !pin_f_q[0] || software_switch_off_i |=> hot_swap_status_flags_o[4])
        else $error("Off state bit low while switched off");

    AST_SOFTWARE_SWITCH_OFF_FORCE: assert property (
        software_switch_off_i |=> hot_swap_status_flags_o[4])
        else $error("Software switch-off did not force the off state bit");

    AST_OFF_ALERT_SET: assert property (
        alert_en_i.off_alert && $rose(off_state_d) |=> hot_swap_status_flags_o[5])
        else $error("Switch-off alert not latched");

    AST_CLEAR_SELF: assert property (
        clear_q && !clear_req_i |=> !clear_q)
        else $error("Clear bit did not return to zero");

    AST_CLEAR_PERSIST: assert property (
        clear_q && conv_src |=> hot_swap_status_flags_o[1])
        else $error("Clear masked an active conversion source");

endmodule : hot_swap_status_flags

// >>> shared/hot_swap_status_consts.svh
// Constants for the hot swap status byte logic and its serial read port.
// Assumes inclusion by bare name from the design files.
`ifndef HOT_SWAP_STATUS_CONSTS_SVH
`define HOT_SWAP_STATUS_CONSTS_SVH

// Status byte field positions
`define ST_CONV_NOW 3'd0
`define ST_CONV_ALERT 3'd1
`define ST_SW_OC 3'd2
`define ST_FAIL_ALERT 3'd3
`define ST_OFF_STATE 3'd4
`define ST_OFF_ALERT 3'd5
`define STATUS_RESET 8'h00
// Synchroniser reset levels {switch overcurrent, on pin}: no overcurrent, switch on
`define PIN_SYNC_RESET 2'b01

// Conversion run lengths
`define CONV_RUN_LEN 3'd3
`define CONV_TRIP_LEN 3'd4
`define CONV_RUN_MAX 3'd7

// Serial port
`define SER_BITS 4'd8
`define SER_ADDR_DEFAULT 7'h2a

`endif

// >>> shared/hot_swap_status_pkg.sv
// Types shared by the status byte logic and its serial read port.
// Assumes the constants header is on the include path.
package hot_swap_status_pkg;

    // Alert enable bits as held by the alert enable register
    typedef struct packed {
        logic off_alert;
        logic failure_alert_enable;
        logic conv_four;
        logic conv_single;
    } alert_en_s;

    // Serial slave states
    typedef enum logic [2:0] {
        SER_IDLE,
        SER_ADDR,
        SER_ACK,
        SER_TX,
        SER_MACK,
        SER_WDATA
    } ser_state_e;

endpackage : hot_swap_status_pkg

// >>> rtl/status_serial_slave.sv
// Two-wire serial slave that answers a read with the status byte, sent again on each master acknowledge.
// Assumes open-drain pins resolved outside; sda_o is always low, oe drives it.
`timescale 1ns/100ps
`include "hot_swap_status_consts.svh"
module status_serial_slave
    import hot_swap_status_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = `SER_ADDR_DEFAULT
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic [7:0] tx_byte_i,
    output logic sda_o,
    output logic sda_oe_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Three-stage synchronisers, a level counts once stages two and three agree
    logic [2:0] scl_s_q, sda_s_q;
    logic scl_q, sda_q;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            scl_s_q <= 3'h7;
            sda_s_q <= 3'h7;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_s_q <= {scl_s_q[1:0], scl_i};
            sda_s_q <= {sda_s_q[1:0], sda_i};
            if (scl_s_q[1] == scl_s_q[2]) scl_q <= scl_s_q[2];
            if (sda_s_q[1] == sda_s_q[2]) sda_q <= sda_s_q[2];
        end
    end

    // Filtered levels one stage back for edge detection
    logic scl_p_q, sda_p_q;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl_q;
            sda_p_q <= sda_q;
        end
    end

    logic scl_rise, scl_fall, start_ev, stop_ev;
    assign scl_rise = scl_q & ~scl_p_q;
    assign scl_fall = ~scl_q & scl_p_q;
    assign start_ev = scl_q & scl_p_q & sda_p_q & ~sda_q;
    assign stop_ev = scl_q & scl_p_q & ~sda_p_q & sda_q;

    ////////////////////////////////////////////////////////////////////////////
    // Byte engine; data changes only on SCL low so it never fakes a start/stop
    ser_state_e state_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q;
    logic rd_q, more_q, oe_q;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_q <= SER_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            rd_q <= 1'b0;
            more_q <= 1'b0;
            oe_q <= 1'b0;
        end else if (start_ev) begin
            state_q <= SER_ADDR;
            cnt_q <= 4'h0;
            oe_q <= 1'b0;
        end else if (stop_ev) begin
            state_q <= SER_IDLE;
            oe_q <= 1'b0;
        end else begin
            case (state_q)
                SER_ADDR, SER_WDATA: begin
                    if (scl_rise) begin
                        sh_q <= {sh_q[6:0], sda_q};
                        cnt_q <= cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == `SER_BITS) begin
                        if (state_q == SER_WDATA || sh_q[7:1] == DEV_ADDR) begin
                            if (state_q == SER_ADDR) rd_q <= sh_q[0];
                            state_q <= SER_ACK;
                            oe_q <= 1'b1;
                        end else begin
                            state_q <= SER_IDLE;
                        end
                    end
                end
                SER_ACK: begin
                    if (scl_fall) begin
                        cnt_q <= 4'h0;
                        if (rd_q) begin
                            sh_q <= tx_byte_i;
                            oe_q <= ~tx_byte_i[7];
                            state_q <= SER_TX;
                        end else begin
                            oe_q <= 1'b0;
                            state_q <= SER_WDATA;
                        end
                    end
                end
                SER_TX: begin
                    if (scl_rise) begin
                        cnt_q <= cnt_q + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt_q == `SER_BITS) begin
                            oe_q <= 1'b0;
                            state_q <= SER_MACK;
                        end else begin
                            sh_q <= {sh_q[6:0], 1'b0};
                            oe_q <= ~sh_q[6];
                        end
                    end
                end
                SER_MACK: begin
                    if (scl_rise) begin
                        more_q <= ~sda_q;
                    end else if (scl_fall) begin
                        if (more_q) begin
                            // master acknowledge: next byte starts at once
                            cnt_q <= 4'h0;
                            sh_q <= tx_byte_i;
                            oe_q <= ~tx_byte_i[7];
                            state_q <= SER_TX;
                        end else begin
                            state_q <= SER_IDLE;
                        end
                    end
                end
                default: begin
                    oe_q <= 1'b0;
                end
            endcase
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe_o = oe_q;

endmodule : status_serial_slave

// >>> tb/status_read_master.sv
// Behavioural two-wire master that reads the status byte.
// Assumes SDA is open drain with a pull-up resolved in the bench.
`timescale 1ns/100ps
module status_read_master (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    // Both lines start released, so the bus idles high
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end

    // Half bit of 12 clocks keeps each level above the slave filter span
    task hp;
        repeat (12) @(posedge clk_i);
        #1;
    endtask : hp

    ////////////////////////////////////////////////////////////////////////
    // status read of n bytes, last byte kept in d
    task read_byte(input logic [6:0] addr, input int n, output logic ackd,
                   output logic [7:0] d);
        logic [7:0] hdr;
        hdr = {addr, 1'b1};
        d = 8'h00;
        hp();
        sda_low_o = 1'b1;
        hp();
        scl_o = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            sda_low_o = ~hdr[i];
            hp();
            scl_o = 1'b1;
            hp();
            scl_o = 1'b0;
        end
        // Release SDA so the addressed slave can acknowledge
        sda_low_o = 1'b0;
        hp();
        scl_o = 1'b1;
        hp();
        ackd = ~sda_i;
        scl_o = 1'b0;
        for (int b = 0; b < n; b++) begin
            for (int i = 7; i >= 0; i--) begin
                hp();
                scl_o = 1'b1;
                hp();
                d = {d[6:0], sda_i};
                scl_o = 1'b0;
            end
            // Acknowledge asks for one more byte; the last byte gets none
            sda_low_o = (b < n - 1);
            hp();
            scl_o = 1'b1;
            hp();
            scl_o = 1'b0;
            // After the last byte SDA goes low now, ready for the stop
            sda_low_o = (b == n - 1);
        end
        hp();
        scl_o = 1'b1;
        hp();
        sda_low_o = 1'b0;
        hp();
    endtask : read_byte
endmodule : status_read_master

// >>> tb/hot_swap_status_flags_tb_top.sv
// Self-checking bench for the status byte logic, retry and latch-off builds.
// Assumes the package and header are compiled first.
`timescale 1ns/100ps
module hot_swap_status_flags_tb_top;
    import hot_swap_status_pkg::*;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic conv_done_i = 1'b0;
    logic conv_over_i = 1'b0;
    alert_en_s alert_en_i = 4'h0;
    logic clear_req_i = 1'b0;
    logic software_switch_off_i = 1'b0;
    logic on_pin_i = 1'b1;
    logic switch_overcurrent_raw_i = 1'b0;
    logic scl_w, sda_w, m_low, s_o, s_oe, clr_busy;
    logic [7:0] st, st_lo;
    int failures = 0;
    int cmp_count = 0;

    // 200 MHz clock
    always #2.5 clk_i = ~clk_i;

    // Pull-up: low when either party pulls
    assign sda_w = (m_low || (s_oe && !s_o)) ? 1'b0 : 1'b1;

    hot_swap_status_flags #(.AUTO_RETRY(1'b1)) hot_swap_status_flags_inst (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .conv_done_i(conv_done_i),
        .conv_over_i(conv_over_i), .alert_en_i(alert_en_i), .clear_req_i(clear_req_i),
        .software_switch_off_i(software_switch_off_i), .on_pin_i(on_pin_i),
        .switch_overcurrent_raw_i(switch_overcurrent_raw_i), .scl_i(scl_w),
        .sda_i(sda_w), .sda_o(s_o), .sda_oe_o(s_oe),
        .hot_swap_status_flags_o(st), .clear_busy_o(clr_busy));

    // Latch-off build shares the stimulus; its serial port stays idle
    hot_swap_status_flags #(.AUTO_RETRY(1'b0)) hot_swap_status_flags_lo_inst (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .conv_done_i(conv_done_i),
        .conv_over_i(conv_over_i), .alert_en_i(alert_en_i), .clear_req_i(clear_req_i),
        .software_switch_off_i(software_switch_off_i), .on_pin_i(on_pin_i),
        .switch_overcurrent_raw_i(switch_overcurrent_raw_i), .scl_i(1'b1),
        .sda_i(1'b1), .sda_o(), .sda_oe_o(),
        .hot_swap_status_flags_o(st_lo), .clear_busy_o());

    status_read_master status_read_master_inst (
        .clk_i(clk_i), .sda_i(sda_w), .scl_o(scl_w), .sda_low_o(m_low));

    ////////////////////////////////////////////////////////////////////////
    task tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick

    task chk(input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : chk

    task summarize;
        if (failures == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : summarize

    task conv(input logic over);
        conv_done_i = 1'b1;
        conv_over_i = over;
        tick(1);
        conv_done_i = 1'b0;
        conv_over_i = 1'b0;
    endtask : conv

    // Clear pulse; readback must rise and then drop by itself
    task do_clear;
        logic seen;
        seen = 1'b0;
        clear_req_i = 1'b1;
        tick(1);
        clear_req_i = 1'b0;
        for (int i = 0; i < 3 && !seen; i++) begin
            seen = clr_busy;
            tick(1);
        end
        chk(8'h01, {7'h0, seen});
        tick(2);
        chk(8'h00, {7'h0, clr_busy});
    endtask : do_clear

    ////////////////////////////////////////////////////////////////////////
    // Back-to-back over conversions, then a break in the run
    task t_conv;
        conv(1'b1);
        conv(1'b1);
        tick(2);
        chk(8'h00, st);
        conv(1'b1);
        tick(3);
        chk(8'h01, st);
        conv(1'b0);
        tick(3);
        chk(8'h00, st);
        alert_en_i.conv_single = 1'b1;
        conv(1'b1);
        tick(3);
        chk(8'h02, st);
        // Last conversion still over, so the source persists through the clear
        do_clear();
        chk(8'h02, st);
        conv(1'b0);
        do_clear();
        chk(8'h00, st);
        // Four-in-a-row alert: the third over conversion must not trip it
        alert_en_i.conv_single = 1'b0;
        alert_en_i.conv_four = 1'b1;
        repeat (3) conv(1'b1);
        tick(3);
        chk(8'h01, st);
        conv(1'b1);
        tick(3);
        chk(8'h03, st);
        conv(1'b0);
        do_clear();
        chk(8'h00, st);
    endtask : t_conv

    // Switch failure with the source held through a clear
    task t_fail;
        alert_en_i.failure_alert_enable = 1'b1;
        switch_overcurrent_raw_i = 1'b1;
        tick(8);
        chk(8'h0c, st);
        do_clear();
        chk(8'h0c, st);
        switch_overcurrent_raw_i = 1'b0;
        tick(8);
        chk(8'h08, st);
        chk(8'h0c, st_lo);
        do_clear();
        chk(8'h00, st);
        chk(8'h00, st_lo);
    endtask : t_fail

    // On input and software switch-off
    task t_off;
        alert_en_i.off_alert = 1'b1;
        on_pin_i = 1'b0;
        tick(8);
        chk(8'h30, st);
        on_pin_i = 1'b1;
        tick(8);
        chk(8'h20, st);
        do_clear();
        chk(8'h00, st);
        software_switch_off_i = 1'b1;
        tick(4);
        chk(8'h30, st);
    endtask : t_off

    // Serial read of the byte, then a read to a foreign address
    task t_read;
        logic ackd;
        logic [7:0] d;
        status_read_master_inst.read_byte(7'h2a, 1, ackd, d);
        chk(8'h01, {7'h0, ackd});
        chk(8'h30, d);
        // Master acknowledge: the second byte is a fresh copy of the status
        status_read_master_inst.read_byte(7'h2a, 2, ackd, d);
        chk(8'h30, d);
        status_read_master_inst.read_byte(7'h2b, 1, ackd, d);
        chk(8'h00, {7'h0, ackd});
    endtask : t_read

    ////////////////////////////////////////////////////////////////////////
    initial begin
        tick(1);
        tick(4);
        chk(8'h00, st);
        chk(8'h00, {7'h0, clr_busy});
        tick(1);
        // Off alert enabled across the release: leaving reset is no switch-off
        alert_en_i.off_alert = 1'b1;
        sys_rst_i = 1'b0;
        tick(10);
        chk(8'h00, st);
        t_conv();
        t_fail();
        t_off();
        t_read();
        summarize();
    end

    // Watchdog well beyond the roughly 1800 cycles the tests need
    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        summarize();
    end
endmodule : hot_swap_status_flags_tb_top
